/* rtl/cafm_match.sv */
// acceptance filters, masks, mask selection and the register bus slave
`timescale 1ns/1ps
`include "cafm_defs.svh"

module cafm_match (
    // clock, reset, enable
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     ce_i,

    // wishbone slave
    input  wire logic                     cyc_i,
    input  wire logic                     stb_i,
    input  wire logic                     we_i,
    input  wire logic [7:0]               adr_i,
    input  wire logic [3:0]               sel_i,
    input  wire logic [31:0]              dat_i,
    output logic      [31:0]              dat_o,
    output logic                          ack_o,

    // protocol engine
    input  wire logic                     id_valid_i,
    input  wire cafm_pkg::cafm_msg_id_type msg_i,
    output cafm_pkg::cafm_result_type     result_o
);

    // register storage
    logic [15:0] fsid [`CAFM_NUM_FILTERS];
    logic [15:0] feid [`CAFM_NUM_FILTERS];
    logic [15:0] msid [`CAFM_NUM_MASKS];
    logic [15:0] meid [`CAFM_NUM_MASKS];
    logic [15:0] fmsk [2];
    logic [15:0] fen;
    logic [15:0] bpnt [4];

    // next values from the combinational halves
    logic [15:0] next_fsid [`CAFM_NUM_FILTERS];
    logic [15:0] next_feid [`CAFM_NUM_FILTERS];
    logic [15:0] next_msid [`CAFM_NUM_MASKS];
    logic [15:0] next_meid [`CAFM_NUM_MASKS];
    logic [15:0] next_fmsk [2];
    logic [15:0] next_fen;
    logic [15:0] next_bpnt [4];

    // bus state
    cafm_pkg::cafm_bus_state_type bus_state;
    cafm_pkg::cafm_bus_state_type next_bus_state;
    logic [31:0]                  next_dat;
    logic                         req;
    logic                         wr_take;

    // matching
    cafm_pkg::cafm_ident_type     mask_id [`CAFM_NUM_MASKS];
    logic [15:0]                  hits;
    logic                         any_hit;
    logic [3:0]                   hit_index;
    logic [3:0]                   hit_ptr;
    cafm_pkg::cafm_result_type    next_result;

    // true when addr is a word inside [base, base+span)
    function automatic logic in_block(input logic [7:0] addr, input logic [7:0] base,
                                      input logic [7:0] span);
        logic [7:0] d;
        d        = addr - base;
        in_block = (d < span) && (d[1:0] == 2'b00);
    endfunction

    // word index within a block
    function automatic logic [3:0] idx_of(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] d;
        d      = addr - base;
        idx_of = d[5:2];
    endfunction

    // byte-lane write of a 16-bit register, unimplemented bits forced to zero
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] sel, input logic [15:0] impl);
        logic [15:0] m;
        m      = {{8{sel[1]}}, {8{sel[0]}}};
        wmerge = ((wd[15:0] & m) | (old & ~m)) & impl;
    endfunction

    // mask source code that disables masking for a filter
    function automatic logic is_no_mask(input logic [1:0] code);
        is_no_mask = (code == `CAFM_NO_MASK);
    endfunction

    // ------------------------------------------------------------ bus handshake
    assign req     = cyc_i && stb_i;
    assign ack_o   = (bus_state == cafm_pkg::BUS_ACK);
    // writes land on the edge where the master sees ack
    assign wr_take = ack_o && req && we_i;

    always_comb begin
        next_bus_state = bus_state;

        case (bus_state)
            cafm_pkg::BUS_IDLE: begin
                if (req) begin
                    next_bus_state = cafm_pkg::BUS_ACK;
                end
            end

            cafm_pkg::BUS_ACK: begin
                next_bus_state = cafm_pkg::BUS_IDLE;
            end

            default: begin
                next_bus_state = cafm_pkg::BUS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------ read data
    always_comb begin
        logic [3:0]  ri;
        logic [15:0] rd;
        ri = 4'h0;
        rd = 16'h0000;

        if (in_block(adr_i, `CAFM_FSID_BASE, `CAFM_FILTER_SPAN)) begin
            ri = idx_of(adr_i, `CAFM_FSID_BASE);
            rd = fsid[ri] & `CAFM_SID_IMPL;
        end else if (in_block(adr_i, `CAFM_FEID_BASE, `CAFM_FILTER_SPAN)) begin
            ri = idx_of(adr_i, `CAFM_FEID_BASE);
            rd = feid[ri];
        end else if (in_block(adr_i, `CAFM_MSID_BASE, `CAFM_MASK_SPAN)) begin
            ri = idx_of(adr_i, `CAFM_MSID_BASE);
            rd = msid[ri[1:0]] & `CAFM_SID_IMPL;
        end else if (in_block(adr_i, `CAFM_MEID_BASE, `CAFM_MASK_SPAN)) begin
            ri = idx_of(adr_i, `CAFM_MEID_BASE);
            rd = meid[ri[1:0]];
        end else if (in_block(adr_i, `CAFM_BPNT_BASE, `CAFM_BPNT_SPAN)) begin
            ri = idx_of(adr_i, `CAFM_BPNT_BASE);
            rd = bpnt[ri[1:0]];
        end else if (adr_i == `CAFM_FMSK_LOW) begin
            rd = fmsk[0];
        end else if (adr_i == `CAFM_FMSK_HIGH) begin
            rd = fmsk[1];
        end else if (adr_i == `CAFM_FEN) begin
            rd = fen;
        end else if (adr_i == `CAFM_STATUS) begin
            // fields of the latest decision, read only
            rd[`CAFM_ST_HIT]                      = result_o.hit;
            rd[`CAFM_ST_FLT_LSB +: 4]             = result_o.filter;
            rd[`CAFM_ST_FIFO]                     = result_o.to_fifo;
            rd[3:0]                               = result_o.buffer;
        end

        // data only changes while a request is being answered
        next_dat = dat_o;
        if (bus_state == cafm_pkg::BUS_IDLE && req) begin
            next_dat = {16'h0000, rd};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state <= cafm_pkg::BUS_IDLE;
            dat_o     <= 32'h0000_0000;
        end else if (ce_i) begin
            bus_state <= next_bus_state;
            dat_o     <= next_dat;
        end
    end

    // ------------------------------------------------------------ register writes
    always_comb begin
        logic [3:0] wi;
        wi        = 4'h0;

        next_fsid = fsid;
        next_feid = feid;
        next_msid = msid;
        next_meid = meid;
        next_fmsk = fmsk;
        next_fen  = fen;
        next_bpnt = bpnt;

        if (wr_take) begin
            if (in_block(adr_i, `CAFM_FSID_BASE, `CAFM_FILTER_SPAN)) begin
                wi = idx_of(adr_i, `CAFM_FSID_BASE);
                next_fsid[wi] = wmerge(fsid[wi], dat_i, sel_i, `CAFM_SID_IMPL);
            end else if (in_block(adr_i, `CAFM_FEID_BASE, `CAFM_FILTER_SPAN)) begin
                wi = idx_of(adr_i, `CAFM_FEID_BASE);
                next_feid[wi] = wmerge(feid[wi], dat_i, sel_i, `CAFM_FULL_IMPL);
            end else if (in_block(adr_i, `CAFM_MSID_BASE, `CAFM_MASK_SPAN)) begin
                wi = idx_of(adr_i, `CAFM_MSID_BASE);
                next_msid[wi[1:0]] = wmerge(msid[wi[1:0]], dat_i, sel_i,
                                            `CAFM_SID_IMPL);
            end else if (in_block(adr_i, `CAFM_MEID_BASE, `CAFM_MASK_SPAN)) begin
                wi = idx_of(adr_i, `CAFM_MEID_BASE);
                next_meid[wi[1:0]] = wmerge(meid[wi[1:0]], dat_i, sel_i,
                                            `CAFM_FULL_IMPL);
            end else if (in_block(adr_i, `CAFM_BPNT_BASE, `CAFM_BPNT_SPAN)) begin
                wi = idx_of(adr_i, `CAFM_BPNT_BASE);
                next_bpnt[wi[1:0]] = wmerge(bpnt[wi[1:0]], dat_i, sel_i, `CAFM_FULL_IMPL);
            end else if (adr_i == `CAFM_FMSK_LOW) begin
                next_fmsk[0] = wmerge(fmsk[0], dat_i, sel_i, `CAFM_FULL_IMPL);
            end else if (adr_i == `CAFM_FMSK_HIGH) begin
                next_fmsk[1] = wmerge(fmsk[1], dat_i, sel_i, `CAFM_FULL_IMPL);
            end else if (adr_i == `CAFM_FEN) begin
                next_fen = wmerge(fen, dat_i, sel_i, `CAFM_FULL_IMPL);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `CAFM_NUM_FILTERS; i++) begin
                fsid[i] <= `CAFM_ID_RST;
                feid[i] <= `CAFM_ID_RST;
            end

            for (int i = 0; i < `CAFM_NUM_MASKS; i++) begin
                msid[i] <= `CAFM_ID_RST;
                meid[i] <= `CAFM_ID_RST;
            end

            for (int i = 0; i < 4; i++) begin
                bpnt[i] <= `CAFM_BPNT_RST;
            end

            fmsk[0] <= `CAFM_FMSK_RST;
            fmsk[1] <= `CAFM_FMSK_RST;
            fen     <= `CAFM_FEN_RST;
        end else if (ce_i) begin
            fsid <= next_fsid;
            feid <= next_feid;
            msid <= next_msid;
            meid <= next_meid;
            fmsk <= next_fmsk;
            fen  <= next_fen;
            bpnt <= next_bpnt;
        end
    end

    // ------------------------------------------------------------ matching
    genvar gm;
    genvar gf;

    generate
        for (gm = 0; gm < `CAFM_NUM_MASKS; gm++) begin : g_mask
            // mask layout mirrors the filter layout
            assign mask_id[gm] = '{
                standard_identifier: msid[gm][`CAFM_SID_MSB:`CAFM_SID_LSB],
                type_bit:            msid[gm][`CAFM_TYPE_BIT],
                extended_identifier: {msid[gm][`CAFM_EIDH_MSB:0], meid[gm]}};
        end

        for (gf = 0; gf < `CAFM_NUM_FILTERS; gf++) begin : g_filter
            logic [1:0]               src;
            cafm_pkg::cafm_ident_type flt;
            cafm_pkg::cafm_ident_type msk;
            logic                     no_msk;

            // two-bit source per filter, low register for 0-7
            assign src = fmsk[gf / 8][(gf % 8) * 2 +: 2];
            assign no_msk = is_no_mask(src);
            // code 11 is no mask, otherwise the code names the mask
            always_comb begin
                case (src)
                    2'b00: begin
                        msk = mask_id[0];
                    end
                    2'b01: begin
                        msk = mask_id[1];
                    end
                    2'b10: begin
                        msk = mask_id[2];
                    end
                    default: begin
                        // no mask: the comparator forces every position
                        msk = mask_id[0];
                    end
                endcase
            end
            // standard in 15-5, type in 3, extended 17:16 in 1-0
            assign flt = '{
                standard_identifier: fsid[gf][`CAFM_SID_MSB:`CAFM_SID_LSB],
                type_bit:            fsid[gf][`CAFM_TYPE_BIT],
                extended_identifier: {fsid[gf][`CAFM_EIDH_MSB:0], feid[gf]}};

            cafm_filter_cmp u_cmp (
                .enable_i    (fen[gf]),
                .filter_i    (flt),
                .mask_i      (msk),
                .mask_none_i (no_msk),
                .msg_i       (msg_i),
                .hit_o       (hits[gf])
            );
        end
    endgenerate

    cafm_hit_pick u_pick (
        .hits_i  (hits),
        .any_o   (any_hit),
        .index_o (hit_index)
    );

    // buffer pointer of the winning filter
    assign hit_ptr = bpnt[hit_index[3:2]][{hit_index[1:0], 2'b00} +: 4];

    // ------------------------------------------------------------ result
    always_comb begin
        next_result       = result_o;
        next_result.valid = 1'b0;

        if (id_valid_i) begin
            next_result.valid   = 1'b1;
            next_result.hit     = any_hit;
            next_result.filter  = hit_index;
            next_result.buffer  = hit_ptr;
            // pointer code 1111 steers the message into the FIFO
            next_result.to_fifo = any_hit && (hit_ptr == `CAFM_FIFO_PTR);
        end
    end

    // decision registered so its fields hold between pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_o <= '0;
        end else if (ce_i) begin
            result_o <= next_result;
        end
    end

endmodule // cafm_match

/* rtl/cafm_defs.svh */
// offsets, field positions and reset values of the acceptance filter block
`ifndef CAFM_DEFS_SVH
`define CAFM_DEFS_SVH

`define CAFM_NUM_FILTERS   16
`define CAFM_NUM_MASKS     3

// byte addresses on the register bus
`define CAFM_FSID_BASE     8'h00
`define CAFM_FEID_BASE     8'h40
`define CAFM_FILTER_SPAN   8'h40
`define CAFM_MSID_BASE     8'h80
`define CAFM_MEID_BASE     8'h90
`define CAFM_MASK_SPAN     8'h0c
`define CAFM_FMSK_LOW      8'ha0
`define CAFM_FMSK_HIGH     8'ha4
`define CAFM_FEN           8'ha8
`define CAFM_BPNT_BASE     8'hb0
`define CAFM_BPNT_SPAN     8'h10
`define CAFM_STATUS        8'hc0

// standard identifier register fields
`define CAFM_SID_MSB       15
`define CAFM_SID_LSB       5
`define CAFM_TYPE_BIT      3
`define CAFM_EIDH_MSB      1
`define CAFM_SID_IMPL      16'hffeb
`define CAFM_FULL_IMPL     16'hffff

// status register fields
`define CAFM_ST_HIT        15
`define CAFM_ST_FLT_LSB    8
`define CAFM_ST_FIFO       4

// reset values and codes
`define CAFM_ID_RST        16'h0000
`define CAFM_FMSK_RST      16'h0000
`define CAFM_FEN_RST       16'hffff
`define CAFM_BPNT_RST      16'h0000
`define CAFM_NO_MASK       2'b11
`define CAFM_FIFO_PTR      4'hf

`endif

/* rtl/cafm_pkg.sv */
// types shared by the acceptance filter block
package cafm_pkg;

    // identifier delivered by the protocol engine
    typedef struct packed {
        logic [10:0] standard_identifier;
        logic [17:0] extended_identifier;
        logic        is_extended;
    } cafm_msg_id_type;

    // a filter value or a mask, as used by the comparator
    typedef struct packed {
        logic [10:0] standard_identifier;
        logic        type_bit;
        logic [17:0] extended_identifier;
    } cafm_ident_type;

    // outcome of one acceptance decision
    typedef struct packed {
        logic       valid;
        logic       hit;
        logic [3:0] filter;
        logic [3:0] buffer;
        logic       to_fifo;
    } cafm_result_type;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } cafm_bus_state_type;

endpackage

/* rtl/cafm_filter_cmp.sv */
// one acceptance filter: compares a message identifier under a mask
`timescale 1ns/1ps

module cafm_filter_cmp (
    // filter setup
    input  wire logic                     enable_i,
    input  wire cafm_pkg::cafm_ident_type filter_i,
    input  wire cafm_pkg::cafm_ident_type mask_i,
    input  wire logic                     mask_none_i,
    // message
    input  wire cafm_pkg::cafm_msg_id_type msg_i,
    // result
    output logic                          hit_o
);

    cafm_pkg::cafm_ident_type eff_mask;
    logic                     sid_ok;
    logic                     eid_ok;
    logic                     type_ok;

    always_comb begin
        if (mask_none_i) begin
            // no mask: every position compared and frame type enforced
            eff_mask = '{standard_identifier: 11'h7ff, type_bit: 1'b1,
                         extended_identifier: 18'h3ffff};
        end else begin
            eff_mask = mask_i;
        end
    end

    // only positions the mask includes must match
    assign sid_ok = ((msg_i.standard_identifier ^ filter_i.standard_identifier)
                     & eff_mask.standard_identifier) == 11'h000;
    // extended bits only count on extended frames
    assign eid_ok = !msg_i.is_extended ||
                    (((msg_i.extended_identifier ^ filter_i.extended_identifier)
                      & eff_mask.extended_identifier) == 18'h00000);
    // type select only honoured when the mask asks for it
    assign type_ok = !eff_mask.type_bit || (filter_i.type_bit == msg_i.is_extended);

    // disabled filters never accept
    assign hit_o = enable_i && sid_ok && eid_ok && type_ok;

endmodule // cafm_filter_cmp

/* rtl/cafm_hit_pick.sv */
// picks the lowest numbered filter that hit
`timescale 1ns/1ps

module cafm_hit_pick (
    // filter hits
    input  wire logic [15:0] hits_i,
    // choice
    output logic             any_o,
    output logic [3:0]       index_o
);

    always_comb begin
        any_o   = 1'b0;
        index_o = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (hits_i[i]) begin
                any_o   = 1'b1;
                index_o = 4'(i);
            end
        end
    end

endmodule // cafm_hit_pick

/* bench/cafm_match_asserts.sv */
// concurrent checks on the ports of the acceptance filter block
`timescale 1ns/1ps

module cafm_match_asserts (
    // clock, reset, enable
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      ce_i,
    // bus
    input wire logic                      cyc_i,
    input wire logic                      stb_i,
    input wire logic                      we_i,
    input wire logic [7:0]                adr_i,
    input wire logic [31:0]               dat_o,
    input wire logic                      ack_o,
    // identifier path
    input wire logic                      id_valid_i,
    input wire cafm_pkg::cafm_result_type result_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_one_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack stayed high");
    a_ack_has_req: assert property (ack_o |-> $past(cyc_i) && $past(stb_i) && $past(ce_i))
        else $error("ack without request");
    a_req_gets_ack: assert property (cyc_i && stb_i && ce_i && !ack_o && !$past(ack_o) |=> ack_o)
        else $error("request not answered next cycle");
    a_dat_upper_zero: assert property (dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_dat_hold: assert property ($changed(dat_o) |-> ack_o || $past(rst_i))
        else $error("read data changed without ack");
    a_unimpl_zero: assert property (
        ack_o && !$past(we_i) && ($past(adr_i) < 8'h40 || ($past(adr_i) >= 8'h80
        && $past(adr_i) < 8'h8c)) |-> dat_o[4] == 1'b0 && dat_o[2] == 1'b0)
        else $error("unimplemented identifier bits read nonzero");
    a_id_latency: assert property (id_valid_i && ce_i |=> result_o.valid)
        else $error("no decision one cycle after identifier");
    a_valid_cause: assert property (result_o.valid |-> $past(id_valid_i) && $past(ce_i))
        else $error("decision without identifier");
    a_fields_hold: assert property (
        $changed({result_o.hit, result_o.filter, result_o.buffer, result_o.to_fifo})
        |-> result_o.valid || $past(rst_i))
        else $error("decision fields changed between decisions");
    a_fifo_flag: assert property (
        result_o.valid |-> result_o.to_fifo == (result_o.hit && result_o.buffer == 4'hf))
        else $error("fifo flag disagrees with pointer");
    a_nohit_clean: assert property (
        result_o.valid && !result_o.hit |-> !result_o.to_fifo && result_o.filter == 4'h0)
        else $error("miss reports filter or fifo");
    a_ce_freeze: assert property (!ce_i |=> $stable(ack_o) && $stable(result_o))
        else $error("outputs moved with clock enable low");

    c_hit: cover property (result_o.valid && result_o.hit);
    c_fifo: cover property (result_o.valid && result_o.to_fifo);
    c_write: cover property (ack_o && $past(we_i));
endmodule // cafm_match_asserts

bind cafm_match cafm_match_asserts u_cafm_match_asserts (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o),
    .ack_o(ack_o), .id_valid_i(id_valid_i), .result_o(result_o));

/* bench/cafm_engine_model.sv */
// behavioural protocol engine handing received identifiers to the filter block
`timescale 1ns/1ps

module cafm_engine_model (
    // clock
    input  wire logic                      clk_i,
    // command from the bench
    input  wire logic                      send_i,
    input  wire cafm_pkg::cafm_msg_id_type send_msg_i,
    // to the filter block
    output logic                           id_valid_o = 1'b0,
    output cafm_pkg::cafm_msg_id_type      msg_o = '0
);
    // between pulses the identifier toggles so a stale value never looks valid
    always @(posedge clk_i) begin
        id_valid_o <= send_i;
        msg_o      <= send_i ? send_msg_i : ~msg_o;
    end
endmodule // cafm_engine_model

/* bench/tb_top.sv */
// self-checking bench for the acceptance filter block
`timescale 1ns/1ps

module tb_top;
    logic                      clk_i = 1'b0;
    logic                      rst_i = 1'b1;
    logic                      ce_i  = 1'b1;
    logic                      cyc_i = 1'b0;
    logic                      stb_i = 1'b0;
    logic                      we_i  = 1'b0;
    logic [7:0]                adr_i = 8'h00;
    logic [3:0]                sel_i = 4'h0;
    logic [31:0]               dat_i = 32'h0;
    logic [31:0]               dat_o;
    logic                      ack_o;
    logic                      id_valid;
    logic                      send  = 1'b0;
    cafm_pkg::cafm_msg_id_type msg;
    cafm_pkg::cafm_msg_id_type smsg  = '0;
    cafm_pkg::cafm_result_type res;
    int                        err_total = 0;
    int                        cmp_count = 0;
    int                        cycles    = 0;

    always #50 clk_i = ~clk_i;

    cafm_match u_cafm_match (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .id_valid_i(id_valid), .msg_i(msg), .result_o(res));
    cafm_engine_model u_cafm_engine_model (.clk_i(clk_i), .send_i(send), .send_msg_i(smsg),
        .id_valid_o(id_valid), .msg_o(msg));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    // one classic cycle; request held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'h3;
        dat_i <= {16'h0000, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [31:0] q;
        wb(1'b0, a, 16'h0000, q);
        check(q, {16'h0000, e});
    endtask

    function automatic logic [9:0] exp_hit(input logic [3:0] f, input logic [3:0] b);
        return {1'b1, f, b, b == 4'hf};
    endfunction

    // decision lands one edge after the model sees the command
    task automatic ident(input logic [10:0] s, input logic [17:0] e, input logic x,
                         input logic [9:0] exp);
        smsg <= {s, e, x};
        send <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({31'h0, res.valid}, 32'h1);
        check({22'h0, res.hit, res.filter, res.buffer, res.to_fifo}, {22'h0, exp});
    endtask

    task automatic t_reset();
        rd_chk(8'ha0, 16'h0000);
        rd_chk(8'ha4, 16'h0000);
        rd_chk(8'ha8, 16'hffff);
        $display("test reset values done");
    endtask

    task automatic t_enable();
        ident(11'h7ff, 18'h0, 1'b0, exp_hit(4'd0, 4'h0));
        wr(8'ha8, 16'h8000);
        ident(11'h001, 18'h0, 1'b0, exp_hit(4'd15, 4'h0));
        wr(8'ha8, 16'h0c00);
        ident(11'h001, 18'h3ffff, 1'b1, exp_hit(4'd10, 4'h0));
        wr(8'ha8, 16'h0000);
        ident(11'h000, 18'h0, 1'b0, 10'h000);
        ce_i <= 1'b0;
        send <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({31'h0, res.valid}, 32'h0);
        ce_i <= 1'b1;
        $display("test enables done");
    endtask

    task automatic t_regs();
        wr(8'h14, 16'hffff);
        rd_chk(8'h14, 16'hffeb);
        wr(8'h88, 16'hffff);
        rd_chk(8'h88, 16'hffeb);
        wr(8'h7c, 16'ha5a5);
        rd_chk(8'h7c, 16'ha5a5);
        rd_chk(8'h40, 16'h0000);
        wr(8'h98, 16'h5a5a);
        rd_chk(8'h98, 16'h5a5a);
        wr(8'h8c, 16'h1234);
        rd_chk(8'h8c, 16'h0000);
        $display("test register access done");
    endtask

    // mask0 ignores id bit 10, mask1 ignores all, mask2 ignores id bit 0
    task automatic t_msk_sel(input logic [3:0] f);
        logic [3:0] ptr;
        ptr = (f == 4'd9) ? 4'hf : f;
        wr(8'ha8, 16'h0001 << f);
        wr({2'b00, f, 2'b00}, 16'h2aa0);
        wr(8'hb0 + {4'h0, f[3:2], 2'b00}, {12'h000, ptr} << (4 * f[1:0]));
        wr(8'h80, 16'h7fe0);
        wr(8'h84, 16'h0000);
        wr(8'h88, 16'hffc0);
        for (int c = 0; c < 4; c++) begin
            wr(f[3] ? 8'ha4 : 8'ha0, 16'(c) << (2 * f[2:0]));
            ident(11'h154, 18'h0, 1'b0, (c == 1 || c == 2) ? exp_hit(f, ptr) : 10'h0);
            ident(11'h555, 18'h0, 1'b0, (c < 2) ? exp_hit(f, ptr) : 10'h0);
        end
        wr(f[3] ? 8'ha4 : 8'ha0, 16'h0000);
        ident(11'h155, 18'h0, 1'b0, exp_hit(f, ptr));
        rd_chk(8'hc0, {1'b1, 3'b000, f, 3'b000, ptr == 4'hf, ptr});
        $display("test mask select done");
    endtask

    task automatic row(input logic [15:0] ms, input logic [15:0] me, input logic [1:0] cd,
                       input logic [10:0] s, input logic [17:0] e, input logic x,
                       input logic h);
        wr(8'h80, ms);
        wr(8'h90, me);
        wr(8'ha0, {14'h0, cd});
        ident(s, e, x, h ? exp_hit(4'd0, 4'h0) : 10'h000);
    endtask

    // filter 0: id 0x123, extended type, extended value 2_beef
    task automatic t_type();
        wr(8'ha8, 16'h0001);
        wr(8'h00, 16'h246a);
        wr(8'h40, 16'hbeef);
        row(16'hffe3, 16'hffff, 2'b00, 11'h123, 18'h0, 1'b0, 1'b1);
        row(16'hffe3, 16'hffff, 2'b00, 11'h122, 18'h0, 1'b0, 1'b0);
        row(16'hffe3, 16'hffff, 2'b00, 11'h123, 18'h2beef, 1'b1, 1'b1);
        row(16'hffe3, 16'hffff, 2'b00, 11'h123, 18'h3beef, 1'b1, 1'b0);
        row(16'hffe3, 16'hffff, 2'b00, 11'h123, 18'h2beee, 1'b1, 1'b0);
        row(16'hffeb, 16'hffff, 2'b00, 11'h123, 18'h0, 1'b0, 1'b0);
        row(16'hffeb, 16'hffff, 2'b00, 11'h123, 18'h2beef, 1'b1, 1'b1);
        row(16'hffe9, 16'hfffe, 2'b00, 11'h123, 18'h0beee, 1'b1, 1'b1);
        row(16'hffe3, 16'hffff, 2'b11, 11'h123, 18'h0, 1'b0, 1'b0);
        row(16'hffe3, 16'h0000, 2'b11, 11'h123, 18'h2beef, 1'b1, 1'b1);
        row(16'hffe3, 16'h0000, 2'b11, 11'h123, 18'h2beee, 1'b1, 1'b0);
        $display("test frame type done");
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_enable();
        t_regs();
        t_msk_sel(4'd3);
        t_msk_sel(4'd9);
        t_type();
        give_verdict();
    end
endmodule // tb_top
